// file: inc/vip_pkg.sv
// shared constants for the vectored interrupt priority and nesting block
package vip_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_NORMAL_VECTOR = 32'hFFFF001C;
  localparam logic [31:0] ADDR_PRIO_C        = 32'hFFFF0028;
  localparam logic [31:0] ADDR_PRIO_D        = 32'hFFFF002C;
  localparam logic [31:0] ADDR_NEST_CTL      = 32'hFFFF0030;
  localparam logic [31:0] ADDR_TRIG_CFG      = 32'hFFFF0034;
  localparam logic [31:0] ADDR_EDGE_CLR      = 32'hFFFF0038;
  localparam logic [31:0] ADDR_IRQ_NEST      = 32'hFFFF003C;
  localparam logic [31:0] ADDR_FAST_VECTOR   = 32'hFFFF011C;
  localparam logic [31:0] ADDR_FAST_NEST     = 32'hFFFF013C;
  // reset value shared by every register
  localparam logic [31:0] REG_RESET          = 32'h00000000;
  // writable bits; reserved bits read as zero
  localparam logic [31:0] PRIO_C_MASK        = 32'h77777777;
  localparam logic [31:0] PRIO_D_MASK        = 32'h00007777;
  // priority field positions (3 bits each)
  localparam int PWM_PRI_LSB      = 28;
  localparam int EXT3_PRI_LSB     = 24;
  localparam int EXT2_PRI_LSB     = 20;
  localparam int EXT1_PRI_LSB     = 16;
  localparam int EXT0_PRI_LSB     = 12;
  localparam int I2CB_SLV_PRI_LSB = 8;
  localparam int I2CB_MST_PRI_LSB = 4;
  localparam int I2CA_SLV_PRI_LSB = 0;
  localparam int LA_B_PRI_LSB     = 12;
  localparam int LA_A_PRI_LSB     = 8;
  localparam int EXT5_PRI_LSB     = 4;
  localparam int EXT4_PRI_LSB     = 0;
  // control bits and edge clear fields
  localparam int IRQ_NEST_EN_BIT  = 0;
  localparam int FIQ_NEST_EN_BIT  = 1;
  localparam int EDGE_CLR_LO_LSB  = 19;
  localparam int EDGE_CLR_HI_LSB  = 24;
  // source numbers
  localparam int NUM_SRC          = 28;
  localparam int NUM_EXT          = 6;
  localparam int SRC_I2CA_SLV     = 16;
  localparam int SRC_I2CB_MST     = 17;
  localparam int SRC_I2CB_SLV     = 18;
  localparam int SRC_EXT0         = 19;
  localparam int SRC_PWM          = 25;
  localparam int SRC_LA_A         = 26;
  localparam int SRC_LA_B         = 27;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // external trigger encodings
  typedef enum logic [1:0] {
    TRIG_HIGH = 2'b00,
    TRIG_LOW  = 2'b01,
    TRIG_RISE = 2'b10,
    TRIG_FALL = 2'b11
  } vip_trig_t;
endpackage : vip_pkg

// file: rtl/vip_ext_trigger.sv
// external interrupt pin synchroniser, edge latch and level qualifier
`timescale 1ns/100ps
module vip_ext_trigger #(
  parameter int N = 6
) (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // pins and configuration
  input  wire logic [N-1:0]   pin,
  input  wire logic [2*N-1:0] trig_cfg,
  input  wire logic [N-1:0]   edge_clear,
  // qualified requests
  output logic      [N-1:0]   pending
);
  typedef struct packed {
    logic [N-1:0] sync_a;
    logic [N-1:0] sync_b;
    logic [N-1:0] prev;
    logic [N-1:0] latch;
    logic [N-1:0] pending;
  } vip_trig_state_t;

  vip_trig_state_t     st;
  vip_trig_state_t     next_st;
  vip_pkg::vip_trig_t  sel;
  logic                edge_hit;

  // sync_a is read only by sync_b; edges are seen between sync_b and prev
  always_comb begin
    next_st        = st;
    sel            = vip_pkg::TRIG_HIGH;
    edge_hit       = 1'b0;
    next_st.sync_a = pin;
    next_st.sync_b = st.sync_a;
    next_st.prev   = st.sync_b;
    for (int i = 0; i < N; i++) begin
      sel      = vip_pkg::vip_trig_t'(trig_cfg[2*i +: 2]);
      edge_hit = ((sel == vip_pkg::TRIG_RISE) && st.sync_b[i] && !st.prev[i])
              || ((sel == vip_pkg::TRIG_FALL) && !st.sync_b[i] && st.prev[i]);
      // a new edge wins over a clear in the same cycle
      next_st.latch[i] = edge_hit || (st.latch[i] && !edge_clear[i]); // [RULE_16]
      unique case (sel)
        vip_pkg::TRIG_HIGH: next_st.pending[i] = st.sync_b[i];      // [RULE_14]
        vip_pkg::TRIG_LOW:  next_st.pending[i] = !st.sync_b[i];     // [RULE_14]
        vip_pkg::TRIG_RISE: next_st.pending[i] = next_st.latch[i];
        vip_pkg::TRIG_FALL: next_st.pending[i] = next_st.latch[i];
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pending = st.pending;

  // a latched edge only goes away through its clear strobe
  a_edge_held: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
    1'b1 |=> ((($past(st.latch) & ~$past(edge_clear)) & ~st.latch) == '0))
    else $error("edge latch dropped without a clear");
endmodule : vip_ext_trigger

// file: rtl/vip_arbiter.sv
// picks the highest priority pending source below the nesting bar
`timescale 1ns/100ps
module vip_arbiter #(
  parameter int NUM_SRC = 28
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // requests and priorities
  input  wire logic [NUM_SRC-1:0]   pending,
  input  wire logic [3*NUM_SRC-1:0] priority_flat,
  input  wire logic                 use_prio,
  input  wire logic [7:0]           nest_status,
  // winner
  output logic                      active,
  output logic      [4:0]           source,
  output logic      [2:0]           level
);
  typedef struct packed {
    logic       active;
    logic [4:0] source;
    logic [2:0] level;
  } vip_pick_t;

  vip_pick_t  st;
  vip_pick_t  next_st;
  logic [3:0] bar;
  logic [2:0] lvl;

  // level of the lowest set status bit, 8 when nothing is nested
  function automatic logic [3:0] block_level(input logic [7:0] nest);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (nest[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : block_level

  // strict compare keeps the lowest source number on a tie
  always_comb begin
    next_st = '0;
    lvl     = 3'h0;
    bar     = use_prio ? block_level(nest_status) : 4'h8;         // [RULE_07]
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = use_prio ? priority_flat[3*i +: 3] : 3'h0;
      if (pending[i] && ({1'b0, lvl} < bar)
          && (!next_st.active || lvl < next_st.level)) begin      // [RULE_20]
        next_st.active = 1'b1;
        next_st.source = 5'(i);
        next_st.level  = lvl;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.active;
  assign source = st.source;
  assign level  = st.level;

  a_block_below_nest: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
    (use_prio && bar != 4'h8) |=> (!active || {1'b0, level} < $past(bar)))
    else $error("source at or below a nested level was let through");
endmodule : vip_arbiter

// file: rtl/vip_controller.sv
// vectored interrupt priority, nesting and external trigger controller
// Function
// [RULE_01] priority_levels_c holds eight 3-bit priorities: pwm, ext3..0, i2c sources.
// [RULE_02] priority_levels_d holds logic arrays b, a and ext5, ext4; bits 31:15 zero.
// [RULE_03] nesting_control bit 0 enables irq nesting and priorities.
// [RULE_04] nesting_control bit 1 enables fiq nesting and priorities.
// [RULE_05] with nesting off both paths still work, fiq always beats irq.
// [RULE_06] reading normal_vector with irq nesting on sets status bit of its level.
// [RULE_07] a set status bit blocks sources at that level and lower.
// [RULE_08] a write to irq_nest_status clears only its lowest set bit.
// [RULE_09] reading fast_vector with fiq nesting on sets status bit of its level.
// [RULE_10] a write to fast_nest_status clears only its lowest set bit.
// [RULE_11] fast_vector reads zero, base in 22:7, source in 6:2, zero.
// [RULE_12] source numbers follow the system numbering, timer 1 is 3.
// [RULE_13] software reads fast_vector only while servicing a fiq with nesting on.
// [RULE_14] six external inputs, each level or edge triggered.
// [RULE_15] software enables the source and sets its trigger before use.
// [RULE_16] a latched edge stays pending until its clear bit is written.
// [RULE_17] two trigger select bits per input: 11 fall, 10 rise, 01 low, 00 high.
// [RULE_18] ext_edge_clear bits 22:19 clear inputs 3..0, bits 25:24 inputs 5, 4.
// [RULE_19] normal_vector reports the irq source in 6:2 and base in 22:7.
// [RULE_20] equal priorities resolve to the lowest source number.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module vip_controller (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address
  input  wire logic [31:0]                   awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  // axi4-lite write data and response
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic      [1:0]                    bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // axi4-lite read
  input  wire logic [31:0]                   araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic      [31:0]                   rdata,
  output logic      [1:0]                    rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // interrupt sources and settings held elsewhere
  input  wire logic [vip_pkg::NUM_SRC-1:0]   src_request,
  input  wire logic [vip_pkg::NUM_SRC-1:0]   normal_source_enable,
  input  wire logic [vip_pkg::NUM_SRC-1:0]   fast_source_enable,
  input  wire logic [3*vip_pkg::NUM_SRC-1:0] other_priority,
  input  wire logic [15:0]                   vector_base,
  // external interrupt pins
  input  wire logic [vip_pkg::NUM_EXT-1:0]   ext_pin,
  // requests to the core
  output logic                               irq_request,
  output logic                               fiq_request
);
  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] prio_c;
    logic [31:0] prio_d;
    logic [1:0]  nest_ctl;
    logic [11:0] trig_cfg;
    logic [7:0]  irq_nest;
    logic [7:0]  fiq_nest;
    logic [5:0]  ext_clr;
  } vip_regs_t;

  vip_regs_t                        st;
  vip_regs_t                        next_st;
  logic [vip_pkg::NUM_EXT-1:0]      ext_pending;
  logic [vip_pkg::NUM_SRC-1:0]      pend_all;
  logic [3*vip_pkg::NUM_SRC-1:0]    prio_all;
  logic                             irq_active;
  logic [4:0]                       irq_source;
  logic [2:0]                       irq_level;
  logic                             fiq_active;
  logic [4:0]                       fiq_source;
  logic [2:0]                       fiq_level;
  logic                             wr_go;
  logic                             rd_go;
  logic [31:0]                      wmask;
  logic [31:0]                      wdat;
  logic [31:0]                      merged;
  logic [7:0]                       irq_set;
  logic [7:0]                       fiq_set;

  // byte enables widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : strb_mask

  // address decode shared by the read and write paths
  function automatic logic is_mapped(input logic [31:0] addr);
    return (addr == vip_pkg::ADDR_NORMAL_VECTOR) || (addr == vip_pkg::ADDR_PRIO_C)
        || (addr == vip_pkg::ADDR_PRIO_D) || (addr == vip_pkg::ADDR_NEST_CTL)
        || (addr == vip_pkg::ADDR_TRIG_CFG) || (addr == vip_pkg::ADDR_EDGE_CLR)
        || (addr == vip_pkg::ADDR_IRQ_NEST) || (addr == vip_pkg::ADDR_FAST_VECTOR)
        || (addr == vip_pkg::ADDR_FAST_NEST);
  endfunction : is_mapped

  // vector word: zero, base, source number, zero
  function automatic logic [31:0] vec_word(input logic [15:0] base, input logic [4:0] src);
    return {9'h000, base, src, 2'h0};                              // [RULE_11] [RULE_19]
  endfunction : vec_word

  // register readback; write-only clear reads as zero
  function automatic logic [31:0] readback(input logic [31:0] addr);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (addr)
      vip_pkg::ADDR_NORMAL_VECTOR: r = vec_word(vector_base, irq_source); // [RULE_19]
      vip_pkg::ADDR_PRIO_C:        r = st.prio_c;
      vip_pkg::ADDR_PRIO_D:        r = st.prio_d;
      vip_pkg::ADDR_NEST_CTL:      r = {30'h00000000, st.nest_ctl};
      vip_pkg::ADDR_TRIG_CFG:      r = {20'h00000, st.trig_cfg};
      vip_pkg::ADDR_IRQ_NEST:      r = {24'h000000, st.irq_nest};
      vip_pkg::ADDR_FAST_VECTOR:   r = vec_word(vector_base, fiq_source); // [RULE_11]
      vip_pkg::ADDR_FAST_NEST:     r = {24'h000000, st.fiq_nest};
      default:                     r = 32'h00000000;
    endcase
    return r;
  endfunction : readback

  // external inputs: sync, edge latch and level qualify
  vip_ext_trigger #(
    .N          (vip_pkg::NUM_EXT)
  ) u_ext_trigger (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin        (ext_pin),
    .trig_cfg   (st.trig_cfg),                                     // [RULE_17]
    .edge_clear (st.ext_clr),
    .pending    (ext_pending)
  );

  // merge local priority fields over those held elsewhere
  always_comb begin
    prio_all = other_priority;
    pend_all = src_request;                                        // [RULE_12]
    pend_all[vip_pkg::SRC_EXT0 +: vip_pkg::NUM_EXT] = ext_pending;       // [RULE_14]
    prio_all[3*vip_pkg::SRC_PWM      +: 3] = st.prio_c[vip_pkg::PWM_PRI_LSB +: 3];
    prio_all[3*(vip_pkg::SRC_EXT0+3) +: 3] = st.prio_c[vip_pkg::EXT3_PRI_LSB +: 3];
    prio_all[3*(vip_pkg::SRC_EXT0+2) +: 3] = st.prio_c[vip_pkg::EXT2_PRI_LSB +: 3];
    prio_all[3*(vip_pkg::SRC_EXT0+1) +: 3] = st.prio_c[vip_pkg::EXT1_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_EXT0     +: 3] = st.prio_c[vip_pkg::EXT0_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_I2CB_SLV +: 3] = st.prio_c[vip_pkg::I2CB_SLV_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_I2CB_MST +: 3] = st.prio_c[vip_pkg::I2CB_MST_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_I2CA_SLV +: 3] = st.prio_c[vip_pkg::I2CA_SLV_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_LA_B     +: 3] = st.prio_d[vip_pkg::LA_B_PRI_LSB +: 3];
    prio_all[3*vip_pkg::SRC_LA_A     +: 3] = st.prio_d[vip_pkg::LA_A_PRI_LSB +: 3];
    prio_all[3*(vip_pkg::SRC_EXT0+5) +: 3] = st.prio_d[vip_pkg::EXT5_PRI_LSB +: 3];
    prio_all[3*(vip_pkg::SRC_EXT0+4) +: 3] = st.prio_d[vip_pkg::EXT4_PRI_LSB +: 3];
  end

  // irq path; with nesting off priorities and the bar are ignored
  vip_arbiter #(
    .NUM_SRC       (vip_pkg::NUM_SRC)
  ) u_irq_arbiter (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .pending       (pend_all & normal_source_enable),
    .priority_flat (prio_all),
    .use_prio      (st.nest_ctl[vip_pkg::IRQ_NEST_EN_BIT]),        // [RULE_03]
    .nest_status   (st.irq_nest),
    .active        (irq_active),
    .source        (irq_source),
    .level         (irq_level)
  );

  // fiq path, same selection with its own status
  vip_arbiter #(
    .NUM_SRC       (vip_pkg::NUM_SRC)
  ) u_fiq_arbiter (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .pending       (pend_all & fast_source_enable),
    .priority_flat (prio_all),
    .use_prio      (st.nest_ctl[vip_pkg::FIQ_NEST_EN_BIT]),        // [RULE_04]
    .nest_status   (st.fiq_nest),
    .active        (fiq_active),
    .source        (fiq_source),
    .level         (fiq_level)
  );

  // fiq masks irq so the core never sees both at once
  assign fiq_request = fiq_active;
  assign irq_request = irq_active && !fiq_active;                  // [RULE_05]

  // bus channels, register writes and nesting status upkeep
  always_comb begin
    next_st = st;
    wr_go   = st.aw_held && st.w_held;
    rd_go   = arvalid && !st.rvalid;
    wmask   = strb_mask(st.w_strb);
    wdat    = st.w_data & wmask;
    merged  = (readback(st.aw_addr) & ~wmask) | wdat;
    irq_set = 8'h00;
    fiq_set = 8'h00;
    next_st.ext_clr = 6'h00;
    if (awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = is_mapped(st.aw_addr) ? vip_pkg::RESP_OKAY : vip_pkg::RESP_DECERR;
      unique case (st.aw_addr)
        vip_pkg::ADDR_PRIO_C:   next_st.prio_c = merged & vip_pkg::PRIO_C_MASK; // [RULE_01]
        vip_pkg::ADDR_PRIO_D:   next_st.prio_d = merged & vip_pkg::PRIO_D_MASK; // [RULE_02]
        vip_pkg::ADDR_NEST_CTL: next_st.nest_ctl = merged[1:0];
        vip_pkg::ADDR_TRIG_CFG: next_st.trig_cfg = merged[11:0];   // [RULE_17]
        vip_pkg::ADDR_EDGE_CLR: next_st.ext_clr = {wdat[vip_pkg::EDGE_CLR_HI_LSB +: 2],
                                                   wdat[vip_pkg::EDGE_CLR_LO_LSB +: 4]}; // [RULE_18]
        default: ;
      endcase
    end
    // reads answer one cycle after the address is taken
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = readback(araddr);
      next_st.rresp  = is_mapped(araddr) ? vip_pkg::RESP_OKAY : vip_pkg::RESP_DECERR;
      if (araddr == vip_pkg::ADDR_NORMAL_VECTOR && st.nest_ctl[vip_pkg::IRQ_NEST_EN_BIT]
          && irq_active) begin
        irq_set[irq_level] = 1'b1;                                 // [RULE_06]
      end
      if (araddr == vip_pkg::ADDR_FAST_VECTOR && st.nest_ctl[vip_pkg::FIQ_NEST_EN_BIT]
          && fiq_active) begin
        fiq_set[fiq_level] = 1'b1;                                 // [RULE_09]
      end
    end
    // any write drops only the lowest set bit; a set in the same cycle wins
    if (wr_go && st.aw_addr == vip_pkg::ADDR_IRQ_NEST) begin
      next_st.irq_nest = st.irq_nest & (st.irq_nest - 8'h01);      // [RULE_08]
    end
    if (wr_go && st.aw_addr == vip_pkg::ADDR_FAST_NEST) begin
      next_st.fiq_nest = st.fiq_nest & (st.fiq_nest - 8'h01);      // [RULE_10]
    end
    next_st.irq_nest = next_st.irq_nest | irq_set;
    next_st.fiq_nest = next_st.fiq_nest | fiq_set;
  end

  // all control state returns to zero on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // bus outputs; ready terms stay low while a response is pending
  assign awready = !st.aw_held && !st.bvalid;
  assign wready  = !st.w_held && !st.bvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_irq_vec_read;
    rd_go && araddr == vip_pkg::ADDR_NORMAL_VECTOR && st.nest_ctl[0] && irq_active;
  endsequence

  sequence s_fiq_vec_read;
    rd_go && araddr == vip_pkg::ADDR_FAST_VECTOR && st.nest_ctl[1] && fiq_active;
  endsequence

  a_irq_nest_set: assert property (s_irq_vec_read |=> st.irq_nest[$past(irq_level)]) // [RULE_06]
    else $error("irq vector read did not set its nesting bit");

  a_fiq_nest_set: assert property (s_fiq_vec_read |=> st.fiq_nest[$past(fiq_level)]) // [RULE_09]
    else $error("fiq vector read did not set its nesting bit");

  a_irq_one_clear: assert property ( // [RULE_08]
    (wr_go && st.aw_addr == vip_pkg::ADDR_IRQ_NEST && irq_set == 8'h00)
    |=> st.irq_nest == ($past(st.irq_nest) & ($past(st.irq_nest) - 8'h01)))
    else $error("irq nesting write did not clear exactly the lowest bit");

  a_fiq_one_clear: assert property ( // [RULE_10]
    (wr_go && st.aw_addr == vip_pkg::ADDR_FAST_NEST && fiq_set == 8'h00)
    |=> st.fiq_nest == ($past(st.fiq_nest) & ($past(st.fiq_nest) - 8'h01)))
    else $error("fiq nesting write did not clear exactly the lowest bit");

  a_fiq_over_irq: assert property (fiq_request |-> !irq_request) // [RULE_05]
    else $error("irq raised while fiq is requested");

  a_irq_no_nest: assert property (!st.nest_ctl[0] |=> // [RULE_03]
    (st.irq_nest & ~$past(st.irq_nest)) == 8'h00)
    else $error("irq nesting bit set while irq nesting is off");

  a_fiq_no_nest: assert property (!st.nest_ctl[1] |=> // [RULE_04]
    (st.fiq_nest & ~$past(st.fiq_nest)) == 8'h00)
    else $error("fiq nesting bit set while fiq nesting is off");

  a_fast_vec_layout: assert property ( // [RULE_11]
    (rd_go && araddr == vip_pkg::ADDR_FAST_VECTOR) |=> rvalid && rdata[31:23] == 9'h000
    && rdata[1:0] == 2'h0 && rdata[6:2] == $past(fiq_source)
    && rdata[22:7] == $past(vector_base))
    else $error("fast vector word has a wrong field");

  a_prio_reserved: assert property ( // [RULE_01]
    ((st.prio_c & ~vip_pkg::PRIO_C_MASK) == 32'h0) && ((st.prio_d & ~vip_pkg::PRIO_D_MASK) == 32'h0))
    else $error("reserved priority bits became set");

  a_edge_clear_map: assert property ( // [RULE_18]
    (wr_go && st.aw_addr == vip_pkg::ADDR_EDGE_CLR) |=> st.ext_clr ==
    {$past(wdat[25:24]), $past(wdat[22:19])} ##1 st.ext_clr == 6'h00)
    else $error("edge clear strobe mapped or timed wrongly");
endmodule : vip_controller

// file: verification/vip_core_model.sv
// core side model: samples the request pair
`timescale 1ns/100ps
module vip_core_model (
  // clock and requests
  input  wire logic       aclk,
  input  wire logic       irq_request,
  input  wire logic       fiq_request,
  // pair as the core saw it, fiq on top since the core serves it first
  output logic      [1:0] seen
);
  always_ff @(posedge aclk) seen <= {fiq_request, irq_request};
endmodule : vip_core_model

// file: verification/vectored_interrupt_priority_nesting_tb.sv
// bench for the interrupt priority and nesting controller
`timescale 1ns/100ps
module vectored_interrupt_priority_nesting_tb;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid, irq_request, fiq_request;
  logic [1:0] bresp, rresp, seen;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [27:0] src_request = '0, normal_source_enable = '0, fast_source_enable = '0;
  logic [83:0] other_priority = '0;
  logic [15:0] vector_base = 16'hA5C3;
  logic [5:0] ext_pin = '0;
  int n_mismatch = 0, tests_run = 0;
  vip_controller vip_controller_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src_request,
    .normal_source_enable, .fast_source_enable, .other_priority, .vector_base,
    .ext_pin, .irq_request, .fiq_request);
  vip_core_model vip_core_model_inst (.aclk, .irq_request, .fiq_request, .seen);
  always #50 aclk = ~aclk; // 100 ns period
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
  endtask : chk
  // one bus cycle; a write expects resp, a read expects d and resp; the wait is bounded
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [1:0] resp = 2'h0);
    int i;
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) break;
    end
    if (i == 40) n_mismatch++;
    if (i == 40) give_verdict();
    {bready, rready} <= 2'h0;
    if (!w) chk("rdata", rdata, d);
    chk("resp", {30'h0, w ? bresp : rresp}, {30'h0, resp});
  endtask : bus
  task automatic t_regs();
    bus(1'b0, 32'hFFFF0028, 32'h0);
    bus(1'b1, 32'hFFFF0028, 32'hFFFFFFFF);
    bus(1'b0, 32'hFFFF0028, 32'h77777777);
    bus(1'b1, 32'hFFFF002C, 32'hFFFFFFFF);
    bus(1'b0, 32'hFFFF002C, 32'h00007777);
    bus(1'b0, 32'hFFFF0040, 32'h0, 2'h3);
    bus(1'b1, 32'hFFFF0030, 32'h3);
    $display("register test done");
  endtask : t_regs
  // source 3 at level 3 nests first, then source 2 at level 0 nests above it
  task automatic t_irq();
    other_priority[11:9] <= 3'h3;
    normal_source_enable[3:2] <= 2'h3;
    src_request[3] <= 1'b1;
    repeat (4) @(posedge aclk);
    bus(1'b0, 32'hFFFF001C, 32'h0052E18C);
    repeat (2) @(posedge aclk);
    chk("irq blocked", {31'h0, irq_request}, 32'h0);
    src_request[2] <= 1'b1;
    repeat (4) @(posedge aclk);
    bus(1'b0, 32'hFFFF001C, 32'h0052E188);
    bus(1'b0, 32'hFFFF003C, 32'h9);
    bus(1'b1, 32'hFFFF003C, 32'hFF);
    bus(1'b0, 32'hFFFF003C, 32'h8);
    $display("irq nesting test done");
  endtask : t_irq
  // irq from source 2 stays pending while source 3 becomes a fiq
  task automatic t_fiq();
    fast_source_enable[3] <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("core sees", {30'h0, seen}, 32'h2);
    bus(1'b0, 32'hFFFF011C, 32'h0052E18C);
    bus(1'b0, 32'hFFFF013C, 32'h8);
    bus(1'b1, 32'hFFFF013C, 32'hFF);
    bus(1'b0, 32'hFFFF013C, 32'h0);
    $display("fiq nesting test done");
  endtask : t_fiq
  // ext input 0: rising edge held after the pin drops, cleared by strobe, then low level
  task automatic t_ext();
    {src_request, fast_source_enable} <= '0;
    normal_source_enable <= 28'h0080000;
    bus(1'b1, 32'hFFFF0030, 32'h0);
    bus(1'b1, 32'hFFFF0034, 32'h2);
    bus(1'b0, 32'hFFFF0034, 32'h2);
    ext_pin[0] <= 1'b1;
    repeat (6) @(posedge aclk);
    ext_pin[0] <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("edge held", {31'h0, irq_request}, 32'h1);
    bus(1'b0, 32'hFFFF001C, 32'h0052E1CC);
    bus(1'b1, 32'hFFFF0038, 32'h00080000);
    repeat (3) @(posedge aclk);
    chk("edge cleared", {31'h0, irq_request}, 32'h0);
    bus(1'b1, 32'hFFFF0034, 32'h1);
    repeat (6) @(posedge aclk);
    chk("low level", {31'h0, irq_request}, 32'h1);
    $display("external trigger test done");
  endtask : t_ext
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_irq();
    t_fiq();
    t_ext();
    give_verdict();
  end
endmodule : vectored_interrupt_priority_nesting_tb
